// [dv/fb_divider_cfg_tb.sv]
/*
  self-checking bench for the feedback divider configuration block:
  register access, prescaler ratios, bypass, selector lock and routing.
  assumes fbdiv_pkg and fb_divider_cfg are compiled first; the bench
  drives every port itself, on the falling edge of the clock.
*/
`timescale 1ns/1ps
module fb_divider_cfg_tb;
  import fbdiv_pkg::*;
  // ----------------------------------------------------------------
  // signals and tables
  // ----------------------------------------------------------------
  localparam int     pr_tab [8] = '{1, 2, 2, 4, 8, 16, 32, 3}; // low ratio per code
  logic              clock      = 1'b0;
  logic              arst_n     = 1'b0;
  logic              reg_wr     = 1'b0;
  logic              reg_rd     = 1'b0;
  logic [ADDR_W-1:0] reg_addr   = '0;
  logic [7:0]        reg_wdata  = 8'h00;
  logic              stat_lock  = 1'b0;
  logic [5:0]        a_count    = 6'h02;  // swallow count, below b_count
  logic [12:0]       b_count    = 13'h0003;
  logic              ref_div_in = 1'b0;
  logic              pfd_up     = 1'b0;
  logic              pfd_down   = 1'b0;
  logic [7:0]        reg_rdata;
  logic              fb_out;
  logic              status_pin;
  int                num_errors = 0;
  int                n_tests    = 0;

  // 25 ns period
  always #12.5 clock = ~clock;

  fb_divider_cfg dut_u (
    .CLOCK(clock), .ARST_N(arst_n), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .STAT_LOCK(stat_lock),
    .A_COUNT(a_count), .B_COUNT(b_count), .REF_DIV_IN(ref_div_in),
    .PFD_UP(pfd_up), .PFD_DOWN(pfd_down), .REG_RDATA(reg_rdata),
    .FB_OUT(fb_out), .STATUS_PIN(status_pin)
  );

  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask

  // period is a bench count, so a plain int compare is enough here
  task automatic chkn(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      num_errors++;
      $display("[FAIL] t=%0t period got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // access tasks: strobe held for one rising edge
  // ----------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask

  // extra cycle before the compare: read data holds until the next read
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(negedge clock);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
    @(negedge clock);
    chk8(reg_rdata, exp);
  endtask

  // skips the first, possibly irregular, periods after a change;
  // on_pin watches the status pin instead of the feedback output
  task automatic period(input int exp, input bit on_pin);
    int n;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(negedge clock);
        n++;
      end while ((on_pin ? status_pin : fb_out) !== 1'b1 && n < 400);
      if (n >= 400) begin
        num_errors++;
        conclude();
      end
    end
    chkn(n, exp);
  endtask

  // three distinct patterns so a swapped route is caught
  task automatic pin_check(input logic [5:0] code);
    logic [2:0] prv;
    logic       e;
    prv = {pfd_down, pfd_up, ref_div_in};
    for (int k = 0; k < 12; k++) begin
      @(negedge clock);
      case (code)
        6'h02:   e = prv[0];
        6'h05:   e = prv[1];
        6'h06:   e = prv[2];
        default: e = 1'b0;  // ground
      endcase
      chk1(status_pin, e);
      prv = {k[1], k[0] ^ k[2], k[2]};
      {pfd_down, pfd_up, ref_div_in} = prv;
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    rd(ADDR_FB_CTRL, 8'h06);
    rd(ADDR_STAT_SEL, 8'h00);
    rd(10'h018, 8'h00);
    wr(10'h018, 8'hff);
    rd(ADDR_FB_CTRL, 8'h06);
    period(32 * 3 + 2, 1'b0);
    // every code with swallows, then the dual codes without
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_FB_CTRL, {5'h00, 3'(c)});
      period(pr_tab[c] * 3 + ((c >= 2 && c <= 6) ? 2 : 0), 1'b0);
    end
    a_count = 6'h00;
    for (int c = 2; c < 7; c++) begin
      wr(ADDR_FB_CTRL, {5'h00, 3'(c)});
      period(pr_tab[c] * 3, 1'b0);
    end
    // bypass only in fixed-divide codes
    for (int c = 0; c < 8; c++) begin
      if (c < 2 || c == 7) begin
        wr(ADDR_FB_CTRL, {5'h01, 3'(c)});
        rd(ADDR_FB_CTRL, {5'h01, 3'(c)});
        period(pr_tab[c], 1'b0);
      end
    end
    // locked selector keeps its field, low bits still land
    stat_lock = 1'b1;
    wr(ADDR_STAT_SEL, 8'hff);
    rd(ADDR_STAT_SEL, 8'h03);
    pin_check(6'h00);
    stat_lock = 1'b0;
    wr(ADDR_STAT_SEL, 8'h08);
    rd(ADDR_STAT_SEL, 8'h08);
    pin_check(6'h02);
    wr(ADDR_STAT_SEL, 8'h14);
    pin_check(6'h05);
    wr(ADDR_STAT_SEL, 8'h18);
    pin_check(6'h06);
    wr(ADDR_STAT_SEL, 8'h00);
    pin_check(6'h00);
    // internal routes, told apart by their periods on the pin
    wr(ADDR_FB_CTRL, {5'h00, PRE_FD2});
    wr(ADDR_STAT_SEL, 8'h04);
    period(2 * 3, 1'b1);
    wr(ADDR_STAT_SEL, 8'h10);
    period(2, 1'b1);
    // one swallow per feedback cycle of 4*3+1
    a_count = 6'h01;
    wr(ADDR_FB_CTRL, {5'h00, PRE_DM4});
    wr(ADDR_STAT_SEL, 8'h0c);
    period(4 * 3 + 1, 1'b1);
    conclude();
  end
endmodule

// [hdl/fb_divider_cfg.sv]
/*
  feedback divider configuration and divider core of a clock synthesizer
  loop, plus the status pin selector with its reprogramming lock.
  assumes CLOCK is the divided oscillator clock, that the swallow and main
  count values and the status lock bit come from registers on this clock,
  and that the reference divider and phase detector pulses are on it too.
*/
// Functional notes
// - bypass makes main counter divide by one
// - decode codes: fixed 1,2,3; others dual-modulus
// - code 010: 2/3, or 2 when swallow zero
// - code 011: 4/5, or 4 when swallow zero
// - code 100: 8/9, or 8 when swallow zero
// - code 101: 16/17, or 16 when swallow zero
// - code 110 default: 32/33, else 32
// - selector field writes ignored while lock bit set; low two bits still written
// - selector: ground, then six dynamic signals
`timescale 1ns/1ps
module fb_divider_cfg
  import fbdiv_pkg::*;
#(
  parameter int A_W = 6,                     // swallow counter width
  parameter int B_W = 13                     // main counter width
) (
  input  wire logic              CLOCK,
  input  wire logic              ARST_N,
  input  wire logic              REG_WR,     // write strobe
  input  wire logic              REG_RD,     // read strobe
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [7:0]        REG_WDATA,
  input  wire logic              STAT_LOCK,  // lock bit of the status control
  input  wire logic [A_W-1:0]    A_COUNT,    // swallow count
  input  wire logic [B_W-1:0]    B_COUNT,    // main count
  input  wire logic              REF_DIV_IN, // reference divider output
  input  wire logic              PFD_UP,
  input  wire logic              PFD_DOWN,
  output logic [7:0]             REG_RDATA,
  output logic                   FB_OUT,     // feedback divider pulse
  output logic                   STATUS_PIN
);
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // base prescaler ratio of a code
  function automatic logic [5:0] base_ratio(input logic [2:0] code);
    case (code)
      PRE_FD1:  base_ratio = 6'h01;
      PRE_FD2:  base_ratio = 6'h02;
      PRE_DM2:  base_ratio = 6'h02;
      PRE_DM4:  base_ratio = 6'h04;
      PRE_DM8:  base_ratio = 6'h08;
      PRE_DM16: base_ratio = 6'h10;
      PRE_DM32: base_ratio = 6'h20;
      default:  base_ratio = 6'h03;
    endcase
  endfunction

  // dual-modulus codes sit between the fixed ones
  function automatic logic is_dual(input logic [2:0] code);
    is_dual = (code >= PRE_DM2) && (code <= PRE_DM32);
  endfunction

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  logic [7:0]     fb_ctrl_q;                 // feedback_divider_control
  logic [7:0]     stat_sel_q;                // status_pin_select
  logic [7:0]     rdata_q;
  logic [7:0]     rdata_d;
  logic           wr_fb;                     // write hits control register
  logic           wr_sel;                    // write hits selector register
  logic           sel_ok;                    // selector field may change
  logic [7:0]     stat_sel_d;

  assign wr_fb      = REG_WR && (REG_ADDR == ADDR_FB_CTRL);
  assign wr_sel     = REG_WR && (REG_ADDR == ADDR_STAT_SEL);
  assign sel_ok     = !STAT_LOCK;
  // the low two bits are always writable; the field only when unlocked
  assign stat_sel_d = {sel_ok ? REG_WDATA[7:SEL_LSB] : stat_sel_q[7:SEL_LSB],
                       REG_WDATA[SEL_LSB-1:0]};
  assign rdata_d    = (REG_ADDR == ADDR_FB_CTRL)  ? fb_ctrl_q  :
                      (REG_ADDR == ADDR_STAT_SEL) ? stat_sel_q : 8'h00;

  // register writes
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      fb_ctrl_q  <= FB_CTRL_RESET;
      stat_sel_q <= STAT_SEL_RESET;
    end else begin
      if (wr_fb) begin
        fb_ctrl_q <= REG_WDATA;
      end
      if (wr_sel) begin
        stat_sel_q <= stat_sel_d;
      end
    end
  end

  // read data, held until the next read
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q <= 8'h00;
    end else if (REG_RD) begin
      rdata_q <= rdata_d;
    end
  end
  assign REG_RDATA = rdata_q;

  // --------------------------------------------------------------
  // prescaler decode
  // --------------------------------------------------------------
  logic [2:0]     pre_code;                  // prescaler field
  logic           bypass;                    // main counter bypass bit
  logic           dual;                      // dual-modulus mode active
  logic [5:0]     base;                      // base ratio P
  logic [A_W-1:0] a_cnt_q;                   // swallows left in this cycle
  logic [A_W-1:0] a_cnt_d;
  logic           swallow;                   // this prescaler period is P+1
  logic [5:0]     modulus;
  logic           pre_pulse;

  assign pre_code = fb_ctrl_q[PRE_LSB +: 3];
  assign bypass   = fb_ctrl_q[BYPASS_BIT];
  assign dual     = is_dual(pre_code);
  assign base     = base_ratio(pre_code);
  // a zero swallow count leaves the dual modes at the plain ratio
  assign swallow  = dual && (a_cnt_q != '0);
  assign modulus  = base + {5'h00, swallow};

  modulus_prescaler #(
    .MOD_W (6)
  ) u_pre (
    .clk     (CLOCK),
    .arst_n  (ARST_N),
    .modulus (modulus),
    .pulse   (pre_pulse)
  );

  // --------------------------------------------------------------
  // main and swallow counters
  // --------------------------------------------------------------
  // the bypass is only meaningful in fixed modes; in dual modes it
  // still forces one prescaler period per cycle, which software avoids
  logic [B_W-1:0] b_cnt_q;                   // prescaler periods so far
  logic [B_W-1:0] b_cnt_d;
  logic [B_W-1:0] b_eff;                     // effective main count
  logic           n_end;                     // last period of the cycle
  logic           fb_q;
  logic           sw_q;                      // swallow counter output

  assign b_eff   = (bypass || (B_COUNT == '0)) ? B_W'(1) : B_COUNT;
  assign n_end   = pre_pulse && (b_cnt_q >= b_eff - B_W'(1));
  assign b_cnt_d = n_end ? '0 : b_cnt_q + B_W'(1);
  // total = P*B + A: A periods of P+1 then B-A of P (needs A <= B)
  assign a_cnt_d = n_end ? (dual ? A_COUNT : '0) :
                   (a_cnt_q != '0) ? a_cnt_q - A_W'(1) : a_cnt_q;

  // counters advance once per prescaler period
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      b_cnt_q <= '0;
      a_cnt_q <= '0;
    end else if (pre_pulse) begin
      b_cnt_q <= b_cnt_d;
      a_cnt_q <= a_cnt_d;
    end
  end

  // feedback and swallow output pulses
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      fb_q <= 1'b0;
      sw_q <= 1'b0;
    end else begin
      fb_q <= n_end;
      sw_q <= pre_pulse && swallow;
    end
  end
  assign FB_OUT = fb_q;

  // --------------------------------------------------------------
  // status pin selector
  // --------------------------------------------------------------
  logic      stat_q;
  logic      stat_d;
  stat_sel_t sel;

  assign sel = stat_sel_t'(stat_sel_q[7:SEL_LSB]);
  // unlisted codes, including the upper half, sit at ground
  assign stat_d = (sel == SEL_FB_OUT)   ? fb_q       :
                  (sel == SEL_REF_OUT)  ? REF_DIV_IN :
                  (sel == SEL_SWALLOW)  ? sw_q       :
                  (sel == SEL_PRESCALE) ? pre_pulse  :
                  (sel == SEL_PFD_UP)   ? PFD_UP     :
                  (sel == SEL_PFD_DOWN) ? PFD_DOWN   : 1'b0;

  // status pin register
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      stat_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
    end
  end
  assign STATUS_PIN = stat_q;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  AST_BYPASS_EACH: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (pre_pulse && bypass) |=> fb_q) else $error("bypass did not end cycle");
  AST_FIXED_RATIO: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !dual |-> (modulus == base)) else $error("fixed mode swallowed");
  AST_FD3: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (pre_code == PRE_FD3) |-> (modulus == 6'h03)) else $error("code 111 not 3");
  AST_DM2: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (pre_code == PRE_DM2 && a_cnt_q != '0) |-> (modulus == 6'h03)) else $error("2/3 bad");
  AST_DM4: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (pre_code == PRE_DM4 && a_cnt_q == '0) |-> (modulus == 6'h04)) else $error("4 bad");
  AST_DM8: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (pre_code == PRE_DM8 && a_cnt_q != '0) |-> (modulus == 6'h09)) else $error("8/9 bad");
  AST_DM16: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (pre_code == PRE_DM16 && a_cnt_q == '0) |-> (modulus == 6'h10)) else $error("16 bad");
  AST_DM32: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (pre_code == PRE_DM32 && a_cnt_q != '0) |-> (modulus == 6'h21)) else $error("32/33 bad");
  AST_SEL_LOCK: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (wr_sel && STAT_LOCK) |=> $stable(stat_sel_q[7:SEL_LSB])) else $error("locked sel moved");
  AST_SEL_GND: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (sel == SEL_GROUND) ##1 (sel == SEL_GROUND) |-> !stat_q) else $error("ground not low");
  AST_SWALLOW_LOAD: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (n_end && dual) |=> (a_cnt_q == $past(A_COUNT))) else $error("swallow not loaded");
endmodule

// [hdl/fbdiv_pkg.sv]
/*
  shared constants for the feedback divider configuration block:
  register addresses, field positions, reset values and prescaler codes.
  assumes a byte-wide register bank with 10-bit addresses.
*/
package fbdiv_pkg;
  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam int          ADDR_W          = 10;
  localparam logic [9:0]  ADDR_FB_CTRL    = 10'h016; // feedback_divider_control
  localparam logic [9:0]  ADDR_STAT_SEL   = 10'h017; // status_pin_select
  localparam logic [7:0]  FB_CTRL_RESET   = 8'h06;   // prescaler 32/33, no bypass
  localparam logic [7:0]  STAT_SEL_RESET  = 8'h00;   // status pin at ground
  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int          BYPASS_BIT      = 3;       // main counter bypass
  localparam int          PRE_LSB         = 0;       // prescaler code [2:0]
  localparam int          SEL_LSB         = 2;       // selector [7:2]
  // --------------------------------------------------------------
  // prescaler codes
  // --------------------------------------------------------------
  localparam logic [2:0]  PRE_FD1         = 3'h0;
  localparam logic [2:0]  PRE_FD2         = 3'h1;
  localparam logic [2:0]  PRE_DM2         = 3'h2;
  localparam logic [2:0]  PRE_DM4         = 3'h3;
  localparam logic [2:0]  PRE_DM8         = 3'h4;
  localparam logic [2:0]  PRE_DM16        = 3'h5;
  localparam logic [2:0]  PRE_DM32        = 3'h6;
  localparam logic [2:0]  PRE_FD3         = 3'h7;
  // --------------------------------------------------------------
  // status pin selector codes
  // --------------------------------------------------------------
  typedef enum logic [5:0] {
    SEL_GROUND   = 6'h00,
    SEL_FB_OUT   = 6'h01,
    SEL_REF_OUT  = 6'h02,
    SEL_SWALLOW  = 6'h03,
    SEL_PRESCALE = 6'h04,
    SEL_PFD_UP   = 6'h05,
    SEL_PFD_DOWN = 6'h06
  } stat_sel_t;
endpackage

// [hdl/modulus_prescaler.sv]
/*
  programmable-modulus prescaler: one output pulse every MOD cycles.
  assumes the modulus may change between pulses; it is compared live.
*/
`timescale 1ns/1ps
module modulus_prescaler #(
  parameter int MOD_W = 6
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [MOD_W-1:0] modulus,    // divide ratio, 1 or more
  output logic                  pulse       // one cycle per period
);
  logic [MOD_W-1:0] cnt_q;                   // cycles into this period
  logic [MOD_W-1:0] cnt_d;
  logic             last;                    // final cycle of period

  // --------------------------------------------------------------
  // count and wrap
  // --------------------------------------------------------------
  // a modulus of zero behaves as one so the output never stalls
  assign last  = (cnt_q >= modulus - MOD_W'(1)) || (modulus == '0);
  assign cnt_d = last ? '0 : cnt_q + MOD_W'(1);
  assign pulse = last;

  // counter register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
